// [self_test_pkg.sv]
// Constants and types shared by the serial link self-test checker
// Behaviour
// - Enable input starts checking received serial data
// - Pins configure self-test after reset by default
// - Control register 0x24 may configure instead
// - Select code picks pixel clock or oscillator
// - Errored frame drives result low half period
// - Errored frame gives own pulse; only one waits, later ones merge
// - After run, result shows pass or fail
// - Result held until new session, lock loss or reset
// - Held result may drop after lock loss
// - Errored frames counted, readable at 0x25
// - Test covers forward link and back channel
// - On lock in test, result high, checking
// - Enable low stops checking, normal operation
package self_test_pkg;

   // Register offsets
   localparam logic [7:0] CONTROL_OFFSET     = 8'h24;
   localparam logic [7:0] ERROR_COUNT_OFFSET = 8'h25;

   // Control register fields
   localparam int CTRL_ENABLE_BIT   = 0;
   localparam int CTRL_SELECT_LSB   = 1;
   localparam int CTRL_REG_MODE_BIT = 3;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [7:0] COUNT_MAX     = 8'hff;

   // Clock-source select codes
   localparam logic [1:0] SEL_EXTERNAL = 2'h0;
   localparam logic [1:0] SEL_OSC_50   = 2'h1;
   localparam logic [1:0] SEL_OSC_25   = 2'h2;
   localparam logic [1:0] SEL_OSC_12   = 2'h3;

   // Oscillator rates in kHz and the divide counts derived from clk
   localparam int CLK_KHZ    = 250000;
   localparam int OSC_50_KHZ = 50000;
   localparam int OSC_25_KHZ = 25000;
   localparam int OSC_12_KHZ = 12500;
   localparam logic [7:0] DIV_50 = 8'(CLK_KHZ / OSC_50_KHZ);
   localparam logic [7:0] DIV_25 = 8'(CLK_KHZ / OSC_25_KHZ);
   localparam logic [7:0] DIV_12 = 8'(CLK_KHZ / OSC_12_KHZ);
   localparam logic [7:0] HALF_MIN = 8'h01;

   // Session states, Gray coded along idle, wait, check, done
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WAIT  = 2'b01,
      ST_CHECK = 2'b11,
      ST_DONE  = 2'b10
   } state_type;

   // Events from the link receiver, one-cycle pulses
   typedef struct packed {
      logic pixel_tick;
      logic frame_end;
      logic payload_error;
      logic back_channel_error;
   } link_event_type;

endpackage

// [serial_link_self_test_checker.sv]
// At-speed self-test checker on the receive side of the serial link
`timescale 1ns/1ps
module serial_link_self_test_checker (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   // Pins
   input  wire logic                         self_test_enable_pin,
   input  wire logic                         test_clock_select_low,
   input  wire logic                         test_clock_select_high,
   // Receiver status and events
   input  wire logic                         rx_lock,
   input  wire self_test_pkg::link_event_type link_event,
   // Register port from the serial control slave
   input  wire logic                         reg_write,
   input  wire logic                         reg_read,
   input  wire logic [7:0]                   reg_addr,
   input  wire logic [7:0]                   reg_wdata,
   output logic      [7:0]                   reg_rdata,
   // Results
   output logic                              pass_out,
   output logic                              test_active,
   output logic      [1:0]                   test_clock_source
);


   // Saturating increment, shared by the period and error counters.
   // Wrapping would make a badly broken link look clean again.
   function automatic logic [7:0] sat_inc(input logic [7:0] value);
      logic [7:0] result;
      result = value;
      if (value != self_test_pkg::COUNT_MAX) begin
         result = value + 8'h01;
      end
      return result;
   endfunction

   // Divide count of clk for each internal oscillator rate
   function automatic logic [7:0] divide_for(input logic [1:0] code);
      logic [7:0] count;
      count = self_test_pkg::HALF_MIN;
      case (code)
         self_test_pkg::SEL_EXTERNAL: begin
            count = self_test_pkg::HALF_MIN;
         end
         self_test_pkg::SEL_OSC_50: begin
            count = self_test_pkg::DIV_50;
         end
         self_test_pkg::SEL_OSC_25: begin
            count = self_test_pkg::DIV_25;
         end
         self_test_pkg::SEL_OSC_12: begin
            count = self_test_pkg::DIV_12;
         end
      endcase
      return count;
   endfunction

   // Half of a measured test-clock period, never below one clk cycle.
   // A pixel clock near clk rate cannot give a shorter visible pulse.
   function automatic logic [7:0] half_of(input logic [7:0] period);
      logic [7:0] half;
      half = period >> 1;
      if (half < self_test_pkg::HALF_MIN) begin
         half = self_test_pkg::HALF_MIN;
      end
      return half;
   endfunction

   // Session and counter state
   self_test_pkg::state_type state_q;
   self_test_pkg::state_type state_d;
   logic [7:0]               ctrl_q;
   logic [7:0]               ctrl_d;
   logic [7:0]               count_q;
   logic [7:0]               count_d;
   logic [7:0]               div_q;
   logic [7:0]               div_d;
   logic [7:0]               cycles_q;
   logic [7:0]               cycles_d;
   logic [7:0]               period_q;
   logic [7:0]               period_d;
   logic [7:0]               pulse_q;
   logic [7:0]               pulse_d;
   logic                     pending_q;
   logic                     pending_d;
   logic                     frame_err_q;
   logic                     frame_err_d;

   // Next values of the registered outputs
   logic [7:0]               rdata_d;
   logic                     pass_d;
   logic                     active_d;
   logic [1:0]               source_d;

   // Decoded configuration and per-cycle events
   logic                     reg_mode;
   logic                     run_enable;
   logic [1:0]               select;
   logic                     check_tick;
   logic                     link_fault;
   logic                     frame_bad;
   logic                     session_start;

   // Pins rule by default; the mode bit hands control to software
   always_comb begin
      reg_mode   = ctrl_q[self_test_pkg::CTRL_REG_MODE_BIT];
      run_enable = self_test_enable_pin;
      select     = {test_clock_select_low,
                    test_clock_select_high};
      if (reg_mode) begin
         run_enable = ctrl_q[self_test_pkg::CTRL_ENABLE_BIT];
         select     = ctrl_q[self_test_pkg::CTRL_SELECT_LSB +: 2];
      end
   end

   // Register port: control is read-write, the error count read-only
   always_comb begin
      ctrl_d  = ctrl_q;
      rdata_d = reg_rdata;
      if (reg_write && reg_addr == self_test_pkg::CONTROL_OFFSET) begin
         ctrl_d = reg_wdata;
      end
      if (reg_read) begin
         if (reg_addr == self_test_pkg::CONTROL_OFFSET) begin
            rdata_d = ctrl_q;
         end else if (reg_addr == self_test_pkg::ERROR_COUNT_OFFSET) begin
            rdata_d = count_q;
         end else begin
            rdata_d = self_test_pkg::UNMAPPED_READ;
         end
      end
   end

   // Test-clock enable: pixel tick or a divided oscillator pulse.
   // The period is measured in clk cycles so the pulse width follows it.
   always_comb begin
      div_d      = div_q;
      check_tick = 1'b0;
      if (select == self_test_pkg::SEL_EXTERNAL) begin
         check_tick = link_event.pixel_tick;
         div_d      = 8'h00;
      end else if (div_q == 8'h00) begin
         check_tick = 1'b1;
         div_d      = divide_for(select) - 8'h01;
      end else begin
         div_d = div_q - 8'h01;
      end
      cycles_d = sat_inc(cycles_q);
      period_d = period_q;
      if (check_tick) begin
         period_d = sat_inc(cycles_q);
         cycles_d = 8'h00;
      end
   end

   // Session sequencing, frame error capture and result pulses
   always_comb begin
      state_d       = state_q;
      count_d       = count_q;
      frame_err_d   = frame_err_q;
      pulse_d       = pulse_q;
      pending_d     = pending_q;
      link_fault    = link_event.payload_error |
                      link_event.back_channel_error;
      frame_bad     = frame_err_q | link_fault;
      session_start = run_enable &&
                      (state_q == self_test_pkg::ST_IDLE ||
                       state_q == self_test_pkg::ST_DONE);
      unique case (state_q)
         self_test_pkg::ST_IDLE: begin
            if (run_enable) begin
               state_d = self_test_pkg::ST_WAIT;
            end
         end
         self_test_pkg::ST_WAIT: begin
            if (!run_enable) begin
               state_d = self_test_pkg::ST_IDLE;
            end else if (rx_lock) begin
               state_d = self_test_pkg::ST_CHECK;
            end
         end
         self_test_pkg::ST_CHECK: begin
            if (!run_enable) begin
               state_d = self_test_pkg::ST_DONE;
            end else if (!rx_lock) begin
               state_d = self_test_pkg::ST_WAIT;
            end
         end
         self_test_pkg::ST_DONE: begin
            if (run_enable) begin
               state_d = self_test_pkg::ST_WAIT;
            end else if (!rx_lock) begin
               state_d = self_test_pkg::ST_IDLE;
            end
         end
      endcase
      if (state_q == self_test_pkg::ST_CHECK) begin
         // One pulse that cannot start yet waits; further errored frames meanwhile merge into it
         if (pulse_q != 8'h00) begin
            pulse_d = pulse_q - 8'h01;
         end else if (pending_q) begin
            pulse_d   = half_of(period_q);
            pending_d = 1'b0;
         end
         frame_err_d = frame_err_q | link_fault;
         if (link_event.frame_end) begin
            // A fault on the closing cycle still counts for this frame
            frame_err_d = 1'b0;
            if (frame_bad) begin
               count_d = sat_inc(count_q);
               if (pulse_q == 8'h00 && !pending_q) begin
                  pulse_d = half_of(period_q);
               end else begin
                  pending_d = 1'b1;
               end
            end
         end
      end else begin
         frame_err_d = 1'b0;
         pulse_d     = 8'h00;
         pending_d   = 1'b0;
      end
      if (session_start) begin
         count_d = 8'h00;
      end
   end

   // Output values, registered below so no pin glitches
   always_comb begin
      active_d = (state_d == self_test_pkg::ST_CHECK);
      source_d = select;
      pass_d   = 1'b0;
      unique case (state_d)
         self_test_pkg::ST_IDLE: begin
            pass_d = 1'b0;
         end
         self_test_pkg::ST_WAIT: begin
            pass_d = 1'b0;
         end
         self_test_pkg::ST_CHECK: begin
            pass_d = (pulse_d == 8'h00);
         end
         self_test_pkg::ST_DONE: begin
            pass_d = (count_d == 8'h00);
         end
      endcase
   end

   // State registers; reset loads constants only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q           <= self_test_pkg::ST_IDLE;
         ctrl_q            <= self_test_pkg::CONTROL_RESET;
         count_q           <= 8'h00;
         div_q             <= 8'h00;
         cycles_q          <= 8'h00;
         period_q          <= self_test_pkg::HALF_MIN;
         pulse_q           <= 8'h00;
         pending_q         <= 1'b0;
         frame_err_q       <= 1'b0;
         reg_rdata         <= self_test_pkg::UNMAPPED_READ;
         pass_out          <= 1'b0;
         test_active       <= 1'b0;
         test_clock_source <= self_test_pkg::SEL_EXTERNAL;
      end else begin
         state_q           <= state_d;
         ctrl_q            <= ctrl_d;
         count_q           <= count_d;
         div_q             <= div_d;
         cycles_q          <= cycles_d;
         period_q          <= period_d;
         pulse_q           <= pulse_d;
         pending_q         <= pending_d;
         frame_err_q       <= frame_err_d;
         reg_rdata         <= rdata_d;
         pass_out          <= pass_d;
         test_active       <= active_d;
         test_clock_source <= source_d;
      end
   end

endmodule

// [self_test_chk.sv]
// Checker of the self-test result and session outputs
`timescale 1ns/1ps
module self_test_chk (input wire logic clk, rst_b, self_test_enable_pin,
   rx_lock, test_active, pass_out);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // A result pulse begins while checking
   sequence s_pulse_start;
      test_active && $fell(pass_out);
   endsequence
   // Two idle cycles with enable low and lock held
   sequence s_quiet_hold;
      !self_test_enable_pin && !test_active && rx_lock ##1
      !self_test_enable_pin && !test_active && rx_lock;
   endsequence
   AST_PULSE: assert property (s_pulse_start |->
      ##[1:64] (pass_out || !test_active)) else $error("pulse too long");
   AST_PASS_HIGH: assert property ($rose(test_active) |->
      pass_out) else $error("result low at check start");
   AST_LOCK_DROP: assert property (!rx_lock |=>
      !test_active) else $error("checking without lock");
   AST_HOLD: assert property (s_quiet_hold |->
      $stable(pass_out)) else $error("held result changed");
   AST_STOP: assert property ($fell(self_test_enable_pin) |-> ##[1:4]
      !test_active) else $error("still active after stop");
   AST_RUN: assert property (self_test_enable_pin && rx_lock [*8]
      |-> test_active) else $error("not active in test");
endmodule
bind serial_link_self_test_checker self_test_chk i_chk (.*);

// [link_model.sv]
// Far-side link model sending frames with optional payload errors
`timescale 1ns/1ps
module link_model (input wire logic clk, err,
   output self_test_pkg::link_event_type ev);
   logic [3:0] n_q = 4'h0;
   // Sixteen-cycle frames; a fault lands mid-frame
   always_ff @(posedge clk) n_q <= n_q + 4'h1;
   // Pixel tick always present, as external-clock mode needs
   assign ev = '{1'b1, n_q == 4'hf, err && n_q == 4'h7, 1'b0};
endmodule

// [serial_link_self_test_checker_tb.sv]
// Bench for the serial link self-test checker
`timescale 1ns/1ps
module serial_link_self_test_checker_tb;
   logic clk = 1'b0, rst_b = 1'b0, en = 1'b0, lk = 1'b0, err = 1'b0;
   logic rd = 1'b0, pass, act;
   logic [1:0] tsrc;
   logic [7:0] rdata;
   int num_errors = 0, total_checks = 0, lows = 0;
   self_test_pkg::link_event_type ev;
   initial forever #2 clk = ~clk;
   // Pulses are one clk cycle here, the half-period floor, so count edges, not samples
   always @(negedge pass) lows++;
   link_model i_link_model (.clk(clk), .err(err), .ev(ev));
   serial_link_self_test_checker i_serial_link_self_test_checker (.clk(clk),
      .rst_b(rst_b), .self_test_enable_pin(en), .test_clock_select_low(1'b0),
      .test_clock_select_high(1'b0), .rx_lock(lk), .link_event(ev),
      .reg_write(1'b0), .reg_read(rd), .reg_addr(8'h25), .reg_wdata(8'h00),
      .reg_rdata(rdata), .pass_out(pass), .test_active(act),
      .test_clock_source(tsrc));
   task automatic cmp(string s, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Two errored frames, then the count read back
   task automatic run_errored_frames();
      en = 1'b1; lk = 1'b1;
      repeat (40) @(negedge clk);
      cmp("pass", 8'h01, {7'h00, pass});
      cmp("active", 8'h01, {7'h00, act});
      cmp("source", 8'h00, {6'h00, tsrc});
      lows = 0;
      err = 1'b1; repeat (32) @(negedge clk); err = 1'b0;
      repeat (40) @(negedge clk);
      cmp("pulses", 8'h02, 8'(lows));
      rd = 1'b1; repeat (3) @(negedge clk);
      cmp("count", 8'h02, rdata);
      rd = 1'b0;
      en = 1'b0; repeat (4) @(negedge clk);
      cmp("held fail", 8'h00, {7'h00, pass});
      cmp("stopped", 8'h00, {7'h00, act});
   endtask
   // Clean session after a failed one: count cleared, pass held high
   task automatic run_clean_session();
      en = 1'b1; repeat (40) @(negedge clk);
      en = 1'b0; repeat (4) @(negedge clk);
      cmp("held pass", 8'h01, {7'h00, pass});
      rd = 1'b1; repeat (3) @(negedge clk);
      cmp("cleared", 8'h00, rdata);
      rd = 1'b0;
   endtask
   initial begin
      repeat (2000) @(posedge clk);
      num_errors++;
      conclude();
   end
   initial begin
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      run_errored_frames();
      run_clean_session();
      conclude();
   end
endmodule
